// *** hw/mad_datapath.sv ***
// move-and-add datapath: indirect moves, exchange, stack save/restore, adds
`timescale 1ns/1ps
// Operation
// - indirect load reads ram into work register
// - indirect store writes work register into ram
// - pointer is ram word, low byte addresses
// - exchange swaps memory and work register
// - save stores register and flags, pointer +2
// - restore drops pointer by 2, reloads both
// - immediate add updates register and four flags
// - memory add into work register, flags updated
// - add into memory, work register kept
// - add with carry into work register
// - add with carry into memory byte
// - zero flag set exactly on zero result
// - carry flag on unsigned carry out
// - half carry from nibble, signed range overflow
module mad_datapath
   import mad_pkg::*;
#(
   parameter int RAM_DEPTH = 256
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // decoder command
   input  wire logic              cmd_valid,
   input  wire mad_cmd_t          cmd,
   // stack pointer load
   input  wire logic              stack_load,
   input  wire logic [DATA_W-1:0] stack_load_value,
   // state seen by the core
   output logic      [DATA_W-1:0] work_register,
   output mad_flags_t             flags,
   output logic      [DATA_W-1:0] stack_top_pointer,
   output logic                   busy,
   output logic                   done
);

   typedef enum logic [1:0] {
      MAD_S_IDLE,
      MAD_S_WAIT1,
      MAD_S_WAIT2
   } mad_state_t;

   // ==========================================================
   // registers
   mad_state_t        state_reg, state_next;
   mad_op_t           op_reg, op_next;
   logic [ADDR_W-1:0] addr_reg, addr_next;
   logic [DATA_W-1:0] work_reg, work_next;
   mad_flags_t        flag_reg, flag_next;
   logic [DATA_W-1:0] stack_reg, stack_next;
   logic              busy_reg, busy_next;
   logic              done_reg, done_next;

   // ==========================================================
   // ram port, driven by the sequencer
   logic              ram_we;
   logic [ADDR_W-1:0] ram_addr;
   logic [DATA_W-1:0] ram_wdata;
   logic [DATA_W-1:0] ram_rdata;

   mad_ram #(
      .DEPTH (RAM_DEPTH)
   ) u_ram (
      .clk   (clk),
      .rst   (rst),
      .we    (ram_we),
      .addr  (ram_addr),
      .wdata (ram_wdata),
      .rdata (ram_rdata)
   );

   // ==========================================================
   // decode and adder selection
   wire logic     accept    = cmd_valid && (state_reg == MAD_S_IDLE);
   wire logic     op_carry  = (op_reg == MAD_OP_ADDC_AM) || (op_reg == MAD_OP_ADDC_MA);
   wire logic     op_to_mem = (op_reg == MAD_OP_ADD_MA) || (op_reg == MAD_OP_ADDC_MA);
   wire logic     carry_in  = op_carry && flag_reg.carry_flag;
   wire mad_sum_t imm_sum   = mad_add8(work_reg, cmd.imm, 1'b0);
   wire mad_sum_t mem_sum   = mad_add8(work_reg, ram_rdata, carry_in);
   wire logic [DATA_W-1:0] stack_minus = stack_reg - STACK_STEP;
   wire logic [DATA_W-1:0] stack_plus  = stack_reg + STACK_STEP;

   // ==========================================================
   // sequencer
   always_comb begin
      state_next = state_reg;
      op_next    = op_reg;
      addr_next  = addr_reg;
      work_next  = work_reg;
      flag_next  = flag_reg;
      stack_next = stack_load ? stack_load_value : stack_reg;
      done_next  = 1'b0;
      ram_we     = 1'b0;
      ram_addr   = addr_reg;
      ram_wdata  = work_reg;
      case (state_reg)
         MAD_S_IDLE: begin
            ram_addr = cmd.addr;
            if (accept) begin
               op_next    = cmd.op;
               addr_next  = cmd.addr;
               state_next = MAD_S_WAIT1;
               case (cmd.op)
                  MAD_OP_SETA: begin
                     work_next  = cmd.imm;
                     state_next = MAD_S_IDLE;
                     done_next  = 1'b1;
                  end
                  MAD_OP_MOVMA: begin
                     ram_we     = 1'b1;
                     state_next = MAD_S_IDLE;
                     done_next  = 1'b1;
                  end
                  MAD_OP_ADDI: begin
                     work_next  = imm_sum.value;
                     flag_next  = imm_sum.flags;
                     state_next = MAD_S_IDLE;
                     done_next  = 1'b1;
                  end
                  MAD_OP_PUSH: begin
                     ram_addr = stack_reg;
                     ram_we   = 1'b1;
                  end
                  MAD_OP_POP: begin
                     ram_addr   = stack_minus;
                     stack_next = stack_minus;
                  end
                  default: begin
                     // pointer low byte, any other memory operand
                     ram_addr = cmd.addr;
                  end
               endcase
            end
         end
         MAD_S_WAIT1: begin
            state_next = MAD_S_IDLE;
            done_next  = 1'b1;
            case (op_reg)
               MAD_OP_LDI: begin
                  // the high pointer byte is never fetched, so it cannot alias
                  ram_addr   = ram_rdata[ADDR_W-1:0];
                  state_next = MAD_S_WAIT2;
                  done_next  = 1'b0;
               end
               MAD_OP_STI: begin
                  ram_addr = ram_rdata[ADDR_W-1:0];
                  ram_we   = 1'b1;
               end
               MAD_OP_XCH: begin
                  ram_we   = 1'b1;
                  work_next = ram_rdata;
               end
               MAD_OP_PUSH: begin
                  ram_addr   = stack_reg + FLAG_SLOT;
                  ram_wdata  = {FLAG_PAD, flag_reg};
                  ram_we     = 1'b1;
                  stack_next = stack_plus;
               end
               MAD_OP_POP: begin
                  work_next  = ram_rdata;
                  ram_addr   = stack_reg + FLAG_SLOT;
                  state_next = MAD_S_WAIT2;
                  done_next  = 1'b0;
               end
               MAD_OP_ADD_AM, MAD_OP_ADDC_AM, MAD_OP_ADD_MA, MAD_OP_ADDC_MA: begin
                  flag_next = mem_sum.flags;
                  if (op_to_mem) begin
                     ram_wdata = mem_sum.value;
                     ram_we    = 1'b1;
                  end else begin
                     work_next = mem_sum.value;
                  end
               end
               default: begin
                  state_next = MAD_S_IDLE;
               end
            endcase
         end
         MAD_S_WAIT2: begin
            state_next = MAD_S_IDLE;
            done_next  = 1'b1;
            if (op_reg == MAD_OP_POP) begin
               flag_next = mad_flags_t'(ram_rdata[FLAG_W-1:0]);
            end else begin
               work_next = ram_rdata;
            end
         end
         default: begin
            state_next = MAD_S_IDLE;
         end
      endcase
      busy_next = (state_next != MAD_S_IDLE);
   end

   // ==========================================================
   // state update
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= MAD_S_IDLE;
         op_reg    <= MAD_OP_SETA;
         addr_reg  <= ZERO_BYTE;
         work_reg  <= WORK_INIT;
         flag_reg  <= '0;
         stack_reg <= STACK_INIT;
         busy_reg  <= 1'b0;
         done_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         op_reg    <= op_next;
         addr_reg  <= addr_next;
         work_reg  <= work_next;
         flag_reg  <= flag_next;
         stack_reg <= stack_next;
         busy_reg  <= busy_next;
         done_reg  <= done_next;
      end
   end

   assign work_register     = work_reg;
   assign flags             = flag_reg;
   assign stack_top_pointer = stack_reg;
   assign busy              = busy_reg;
   assign done              = done_reg;

   // ==========================================================
   // checks
   default clocking mad_cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // done of the previous op may still be high on the accepting edge
   AST_LDI_TIMING: assert property (
      accept && cmd.op == MAD_OP_LDI |-> ##1 !done_reg ##1 !done_reg ##1 done_reg)
      else $error("indirect load did not finish on the third edge");

   AST_DONE_IDLE: assert property (
      done_reg |-> !busy_reg)
      else $error("done raised while still busy");

   AST_STI_TIMING: assert property (
      accept && cmd.op == MAD_OP_STI |-> ##2 done_reg && flag_reg == $past(flag_reg, 2))
      else $error("indirect store timing or flags wrong");

   AST_XCH_SWAP: assert property (
      state_reg == MAD_S_WAIT1 && op_reg == MAD_OP_XCH
      |-> ram_we && ram_wdata == work_reg ##1 work_reg == $past(ram_rdata))
      else $error("exchange did not swap");

   AST_XCH_TIMING: assert property (
      accept && cmd.op == MAD_OP_XCH |-> ##2 done_reg && flag_reg == $past(flag_reg, 2))
      else $error("exchange timing or flags wrong");

   AST_PUSH_SP: assert property (
      accept && cmd.op == MAD_OP_PUSH && !stack_load
      |-> ##2 stack_reg == $past(stack_reg, 2) + STACK_STEP && flag_reg == $past(flag_reg, 2))
      else $error("save did not advance the pointer by two");

   AST_PUSH_FLAG_BYTE: assert property (
      state_reg == MAD_S_WAIT1 && op_reg == MAD_OP_PUSH
      |-> ram_we && ram_addr == stack_reg + FLAG_SLOT && ram_wdata == {FLAG_PAD, flag_reg})
      else $error("flag byte not saved one above the work register");

   AST_POP_SP: assert property (
      accept && cmd.op == MAD_OP_POP && !stack_load
      |=> stack_reg == $past(stack_reg) - STACK_STEP)
      else $error("restore did not drop the pointer by two");

   AST_POP_FLAGS: assert property (
      state_reg == MAD_S_WAIT2 && op_reg == MAD_OP_POP
      |=> flag_reg == $past(ram_rdata[FLAG_W-1:0]))
      else $error("restore did not reload the flags");

   AST_ADDI_SUM: assert property (
      accept && cmd.op == MAD_OP_ADDI |=> work_reg == 8'($past(work_reg) + $past(cmd.imm)))
      else $error("immediate add result wrong");

   AST_ADDMA_KEEP: assert property (
      state_reg == MAD_S_WAIT1 && op_to_mem |-> ram_we ##1 work_reg == $past(work_reg))
      else $error("memory add disturbed the work register");

   AST_ZERO_FLAG: assert property (
      done_reg && (op_reg == MAD_OP_ADDI || op_reg == MAD_OP_ADD_AM || op_reg == MAD_OP_ADDC_AM)
      |-> flag_reg.zero_flag == (work_reg == ZERO_BYTE))
      else $error("zero flag disagrees with result");

   AST_CARRY_FLAG: assert property (
      accept && cmd.op == MAD_OP_ADDI
      |=> flag_reg.carry_flag == (({1'b0, $past(work_reg)} + {1'b0, $past(cmd.imm)}) > 9'h0FF))
      else $error("carry flag wrong after immediate add");

   AST_HALF_CARRY: assert property (
      accept && cmd.op == MAD_OP_ADDI
      |=> flag_reg.half_carry_flag ==
          (({1'b0, $past(work_reg[NIB_W-1:0])} +
            {1'b0, $past(cmd.imm[NIB_W-1:0])}) > 5'h0F))
      else $error("half carry wrong after immediate add");

   AST_MOVE_FLAGS: assert property (
      state_reg != MAD_S_IDLE && (op_reg == MAD_OP_LDI || op_reg == MAD_OP_XCH)
      |=> $stable(flag_reg))
      else $error("move or exchange changed a flag");

endmodule

// *** hw/mad_pkg.sv ***
// shared constants, command and flag types for the move-and-add datapath
package mad_pkg;

   // ==========================================================
   // widths and reset values
   localparam int         DATA_W     = 8;
   localparam int         ADDR_W     = 8;
   localparam int         NIB_W      = 4;
   localparam int         FLAG_W     = 4;
   localparam logic [7:0] WORK_INIT  = 8'h00;
   localparam logic [7:0] STACK_INIT = 8'h00;
   localparam logic [7:0] ZERO_BYTE  = 8'h00;
   localparam logic [3:0] FLAG_PAD   = 4'h0;

   // ==========================================================
   // stack layout: work register at the pointer, flags one above
   localparam logic [7:0] STACK_STEP = 8'h02;
   localparam logic [7:0] FLAG_SLOT  = 8'h01;

   // ==========================================================
   // commands from the instruction decoder
   typedef enum logic [3:0] {
      MAD_OP_SETA,
      MAD_OP_MOVMA,
      MAD_OP_LDI,
      MAD_OP_STI,
      MAD_OP_XCH,
      MAD_OP_PUSH,
      MAD_OP_POP,
      MAD_OP_ADDI,
      MAD_OP_ADD_AM,
      MAD_OP_ADD_MA,
      MAD_OP_ADDC_AM,
      MAD_OP_ADDC_MA
   } mad_op_t;

   // flag byte: bit0 zero, bit1 carry, bit2 half carry, bit3 signed range
   typedef struct packed {
      logic signed_range_flag;
      logic half_carry_flag;
      logic carry_flag;
      logic zero_flag;
   } mad_flags_t;

   typedef struct packed {
      mad_op_t    op;
      logic [7:0] addr;
      logic [7:0] imm;
   } mad_cmd_t;

   typedef struct packed {
      logic [7:0] value;
      mad_flags_t flags;
   } mad_sum_t;

   // ==========================================================
   // eight-bit adder with all four status flags
   function automatic mad_sum_t mad_add8(input logic [7:0] a,
                                         input logic [7:0] b,
                                         input logic       cin);
      logic [8:0] full;
      logic [4:0] low;
      mad_sum_t   r;
      full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      low  = {1'b0, a[NIB_W-1:0]} + {1'b0, b[NIB_W-1:0]} + {4'h0, cin};
      r.value                   = full[DATA_W-1:0];
      r.flags.zero_flag         = (full[DATA_W-1:0] == ZERO_BYTE);
      r.flags.carry_flag        = full[DATA_W];
      r.flags.half_carry_flag   = low[NIB_W];
      r.flags.signed_range_flag = (a[DATA_W-1] == b[DATA_W-1]) &&
                                  (full[DATA_W-1] != a[DATA_W-1]);
      return r;
   endfunction

endpackage

// *** hw/mad_ram.sv ***
// single-port data ram with registered read data
`timescale 1ns/1ps
module mad_ram
   import mad_pkg::*;
#(
   parameter int DEPTH = 256
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // access port
   input  wire logic              we,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wdata,
   output logic      [DATA_W-1:0] rdata
);

   logic [DATA_W-1:0] mem [DEPTH];

   // ==========================================================
   // storage; read data lag the address by one edge
   always_ff @(posedge clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata <= ZERO_BYTE;
      end else begin
         rdata <= mem[addr];
      end
   end

endmodule

// *** test/mad_mem_model.sv ***
// behavioural model of the data ram and stack bytes behind the datapath
`timescale 1ns/1ps
module mad_mem_model
   import mad_pkg::*;
;
   // ==========================================================
   // storage
   // bytes never written stay unknown, as the real ram is not reset,
   // so a scenario must write a byte before it relies on it
   logic [DATA_W-1:0] mem [256];
endmodule

// *** test/tb_top.sv ***
// self-checking testbench for the move-and-add datapath
`timescale 1ns/1ps
`define CHK(a, b) checks_done++; if ((a) !== (b)) begin errors++; $display("Error t=%0t got %0h exp %0h", $time, a, b); end
module tb_top
   import mad_pkg::*;
;
   // ==========================================================
   // signals and expected state
   logic              clk;
   logic              rst;
   logic              cmd_valid;
   mad_cmd_t          cmd;
   logic              stack_load;
   logic [DATA_W-1:0] stack_load_value;
   logic [DATA_W-1:0] work_register;
   mad_flags_t        flags;
   logic [DATA_W-1:0] stack_top_pointer;
   logic              busy;
   logic              done;
   logic [7:0]        work_exp;
   logic [7:0]        stack_exp;
   mad_flags_t        fl;
   int                errors;
   int                checks_done;

   mad_datapath uut (
      .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd), .stack_load(stack_load),
      .stack_load_value(stack_load_value), .work_register(work_register), .flags(flags),
      .stack_top_pointer(stack_top_pointer), .busy(busy), .done(done));
   mad_mem_model shadow ();

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // ==========================================================
   // helpers
   task automatic stop_test();
      $display("errors=%0d checks_done=%0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // independent sum and flags, {signed range, half carry, carry, zero, value}
   function automatic logic [11:0] exp_add(input logic [7:0] a, input logic [7:0] b,
                                           input logic c);
      logic [8:0] s;
      logic [4:0] l;
      s = {1'b0, a} + {1'b0, b} + {8'h00, c};
      l = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, c};
      return {(a[7] == b[7]) && (s[7] != a[7]), l[4], s[8], s[7:0] == 8'h00, s[7:0]};
   endfunction

   // issue one command at a falling edge, wait for done, update model, compare
   task automatic run(input mad_op_t op, input logic [7:0] ad, input logic [7:0] im);
      int         n;
      int         lat;
      logic [7:0] p;
      logic [7:0] t;
      cmd_valid = 1'b1;
      cmd.op    = op;
      cmd.addr  = ad;
      cmd.imm   = im;
      @(negedge clk);
      cmd_valid = 1'b0;
      n = 1;
      while (done !== 1'b1 && n < 8) begin
         @(negedge clk);
         n++;
      end
      if (n >= 8) begin
         errors++;
         stop_test();
      end
      p   = shadow.mem[ad];
      t   = shadow.mem[ad];
      lat = 2;
      case (op)
         MAD_OP_SETA: begin work_exp = im; lat = 1; end
         MAD_OP_MOVMA: begin shadow.mem[ad] = work_exp; lat = 1; end
         MAD_OP_LDI: begin work_exp = shadow.mem[p]; lat = 3; end
         MAD_OP_STI: shadow.mem[p] = work_exp;
         MAD_OP_XCH: begin shadow.mem[ad] = work_exp; work_exp = t; end
         MAD_OP_PUSH: begin
            shadow.mem[stack_exp] = work_exp;
            shadow.mem[stack_exp + 8'h01] = {4'h0, fl};
            stack_exp = stack_exp + 8'h02;
         end
         MAD_OP_POP: begin
            stack_exp = stack_exp - 8'h02;
            work_exp  = shadow.mem[stack_exp];
            fl        = shadow.mem[stack_exp + 8'h01][3:0];
            lat       = 3;
         end
         MAD_OP_ADDI: begin {fl, work_exp} = exp_add(work_exp, im, 1'b0); lat = 1; end
         MAD_OP_ADD_AM: {fl, work_exp} = exp_add(work_exp, t, 1'b0);
         MAD_OP_ADD_MA: {fl, shadow.mem[ad]} = exp_add(work_exp, t, 1'b0);
         MAD_OP_ADDC_AM: {fl, work_exp} = exp_add(work_exp, t, fl.carry_flag);
         default: {fl, shadow.mem[ad]} = exp_add(work_exp, t, fl.carry_flag);
      endcase
      `CHK(n, lat)
      `CHK(busy, 1'b0)
      `CHK(work_register, work_exp)
      `CHK(flags, fl)
      `CHK(stack_top_pointer, stack_exp)
   endtask

   task automatic set_stack(input logic [7:0] v);
      stack_load       = 1'b1;
      stack_load_value = v;
      @(negedge clk);
      stack_load = 1'b0;
      stack_exp  = v;
      `CHK(stack_top_pointer, stack_exp)
   endtask

   // ==========================================================
   // scenarios
   task automatic t_reset();
      `CHK(work_register, 8'h00)
      `CHK(flags, 4'h0)
      `CHK(stack_top_pointer, 8'h00)
      `CHK(busy, 1'b0)
      `CHK(done, 1'b0)
   endtask

   // pointer word with a nonzero high byte: only the low byte addresses
   task automatic t_moves();
      run(MAD_OP_SETA, 8'h00, 8'h5B);
      run(MAD_OP_MOVMA, 8'h10, 8'h00);
      run(MAD_OP_SETA, 8'h00, 8'hFF);
      run(MAD_OP_MOVMA, 8'h11, 8'h00);
      run(MAD_OP_SETA, 8'h00, 8'hC3);
      run(MAD_OP_MOVMA, 8'h5B, 8'h00);
      run(MAD_OP_ADDI, 8'h00, 8'h3D);
      run(MAD_OP_LDI, 8'h10, 8'h00);
      run(MAD_OP_SETA, 8'h00, 8'hA5);
      run(MAD_OP_STI, 8'h10, 8'h00);
      run(MAD_OP_SETA, 8'h00, 8'h00);
      run(MAD_OP_LDI, 8'h10, 8'h00);
   endtask

   task automatic t_xch();
      run(MAD_OP_SETA, 8'h00, 8'h3C);
      run(MAD_OP_MOVMA, 8'h20, 8'h00);
      run(MAD_OP_SETA, 8'h00, 8'h77);
      run(MAD_OP_XCH, 8'h20, 8'h00);
      run(MAD_OP_XCH, 8'h20, 8'h00);
   endtask

   // second save wraps the pointer past the top of the byte range
   task automatic t_stack();
      set_stack(8'h40);
      run(MAD_OP_SETA, 8'h00, 8'h7F);
      run(MAD_OP_ADDI, 8'h00, 8'h01);
      run(MAD_OP_PUSH, 8'h00, 8'h00);
      run(MAD_OP_ADDI, 8'h00, 8'h80);
      run(MAD_OP_SETA, 8'h00, 8'h11);
      run(MAD_OP_POP, 8'h00, 8'h00);
      run(MAD_OP_XCH, 8'h41, 8'h00);
      run(MAD_OP_XCH, 8'h40, 8'h00);
      set_stack(8'hFE);
      run(MAD_OP_ADDI, 8'h00, 8'hF5);
      run(MAD_OP_PUSH, 8'h00, 8'h00);
      run(MAD_OP_POP, 8'h00, 8'h00);
   endtask

   // every add form against zero, carry, half carry and overflow corners
   task automatic t_add();
      mad_op_t    ops [5];
      logic [7:0] av [5];
      logic [7:0] bv [5];
      ops = '{MAD_OP_ADDI, MAD_OP_ADD_AM, MAD_OP_ADD_MA, MAD_OP_ADDC_AM, MAD_OP_ADDC_MA};
      av  = '{8'h80, 8'h0F, 8'h7F, 8'h12, 8'hFF};
      bv  = '{8'h80, 8'h01, 8'h01, 8'h34, 8'h00};
      for (int o = 0; o < 5; o++) begin
         for (int k = 0; k < 5; k++) begin
            run(MAD_OP_SETA, 8'h00, 8'hFF);
            run(MAD_OP_ADDI, 8'h00, {7'h00, k[0]});
            run(MAD_OP_SETA, 8'h00, bv[k]);
            run(MAD_OP_MOVMA, 8'h30, 8'h00);
            run(MAD_OP_SETA, 8'h00, av[k]);
            run(ops[o], 8'h30, bv[k]);
            run(MAD_OP_XCH, 8'h30, 8'h00);
         end
      end
   endtask

   // ==========================================================
   // main sequence
   initial begin
      errors        = 0;
      checks_done   = 0;
      rst           = 1'b1;
      cmd_valid     = 1'b0;
      cmd           = '0;
      stack_load       = 1'b0;
      stack_load_value = 8'h00;
      work_exp         = 8'h00;
      stack_exp        = 8'h00;
      fl            = '0;
      repeat (10) @(negedge clk);
      rst = 1'b0;
      t_reset();
      t_moves();
      t_xch();
      t_stack();
      t_add();
      stop_test();
   end
endmodule
